// ---- core/aeu_pkg.sv ----
// Constants, field positions and carriers for the uncorrectable error bank.
// Assumes one core clock and a simple strobe register port.
// Functional notes
// - Link protocol error sets status bit 4 unless mask bit 4 is set.
// - Surprise down sets bit 5; bit 5 stays zero without the capable strap.
// - Poisoned packet received sets status bit 12.
// - Flow control protocol violation sets status bit 13.
// - Completion matching no outstanding request sets status bit 16.
// - Receiver buffer overflow sets status bit 17.
// - Malformed packet received sets status bit 18.
// - End-to-end CRC failure sets status bit 19.
// - Unsupported request sets status bit 20.
// - Bit 14 reads zero and ignores writes in status and mask.
// - Bit 15 reads zero in status and mask.
// - Masked events are neither logged nor reported upstream.
// - Mask bits sticky, writable, reset zero; mask gates same-position status.
// - Bit 0 sticky, resets zero, no effect; clearable status, writable mask.
package aeu_pkg;
  // ******************************************************************
  // Bus and register map
  // ******************************************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] UE_STATUS_OFS = 12'h104;
  localparam logic [11:0] UE_MASK_OFS = 12'h108;
  localparam logic [11:0] INT_STATUS_OFS = 12'h180;
  localparam logic [11:0] INT_MASK_OFS = 12'h184;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int unsigned LEGACY_BIT = 0;
  localparam int unsigned LINK_PROTO_BIT = 4;
  localparam int unsigned SDOWN_BIT = 5;
  localparam int unsigned POISON_BIT = 12;
  localparam int unsigned FLOW_BIT = 13;
  localparam int unsigned CPL_TIMEOUT_BIT = 14;
  localparam int unsigned CPL_ABORT_BIT = 15;
  localparam int unsigned UNEXP_CPL_BIT = 16;
  localparam int unsigned OVERFLOW_BIT = 17;
  localparam int unsigned MALFORMED_BIT = 18;
  localparam int unsigned ECRC_BIT = 19;
  localparam int unsigned UNSUP_BIT = 20;
  // Bits 0,4,5,12,13,16..20 hold storage; bit 0 takes no events
  localparam logic [31:0] UE_IMPL_BITS = 32'h001F_3031;
  localparam logic [31:0] UE_EVENT_BITS = 32'h001F_3030;
  localparam logic [31:0] UE_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] UE_MASK_RST = 32'h0000_0000;

  // ******************************************************************
  // Interrupt bank
  // ******************************************************************
  localparam int unsigned INT_W = 2;
  localparam int unsigned INT_LOGGED_BIT = 0;
  localparam int unsigned INT_HIDDEN_BIT = 1;
  localparam logic [1:0] INT_STATUS_RST = 2'h0;
  localparam logic [1:0] INT_MASK_RST = 2'h0;

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic link_protocol;
    logic surprise_down;
    logic poisoned;
    logic flow_credit;
    logic unexpected_cpl;
    logic rcv_overflow;
    logic malformed;
    logic ecrc;
    logic unsupported;
  } aeu_evt_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } aeu_req_t;
endpackage

// ---- core/aeu_sticky_reg.sv ----
// Bank of sticky flops: hardware set, per-bit clear of any number of bits, optional load.
// Assumes rst_n is the power-on reset; no other reset touches it.
`timescale 1ns/1ns
module aeu_sticky_reg #(
  parameter int unsigned WIDTH = 32,
  parameter logic [WIDTH-1:0] IMPL = '1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic [WIDTH-1:0] clr_bits,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic [WIDTH-1:0] q
);
  // ******************************************************************
  // Per-bit storage; absent bits are constant zero
  // ******************************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    if (IMPL[i]) begin : g_impl
      logic bit_r;
      logic bit_nxt;
      // Set wins over a clear in the same cycle
      assign bit_nxt = set_bits[i] | ((load ? load_val[i] : bit_r) & ~clr_bits[i]);
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          bit_r <= RST[i];
        end else begin
          bit_r <= bit_nxt;
        end
      end
      assign q[i] = bit_r;
    end else begin : g_zero
      assign q[i] = 1'b0;
    end
  end
endmodule

// ---- core/aeu_uncorr_err_top.sv ----
// Uncorrectable error status and mask bank for one switch port.
// Assumes event inputs are one-cycle pulses on core_clk and that the
// register master follows the single-cycle strobe protocol.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module aeu_uncorr_err_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic port_rst_n,
  input wire aeu_pkg::aeu_req_t req,
  input wire aeu_pkg::aeu_evt_t evt,
  input wire logic surprise_down_capable,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic err_report,
  output logic [31:0] err_report_vec
);
  // ******************************************************************
  // Decode helpers
  // ******************************************************************
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [31:0] evt_vec(input aeu_pkg::aeu_evt_t e, input logic sd_cap);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[aeu_pkg::LINK_PROTO_BIT] = e.link_protocol;
    v[aeu_pkg::SDOWN_BIT] = e.surprise_down & sd_cap;
    v[aeu_pkg::POISON_BIT] = e.poisoned;
    v[aeu_pkg::FLOW_BIT] = e.flow_credit;
    v[aeu_pkg::UNEXP_CPL_BIT] = e.unexpected_cpl;
    v[aeu_pkg::OVERFLOW_BIT] = e.rcv_overflow;
    v[aeu_pkg::MALFORMED_BIT] = e.malformed;
    v[aeu_pkg::ECRC_BIT] = e.ecrc;
    v[aeu_pkg::UNSUP_BIT] = e.unsupported;
    return v;
  endfunction

  // ******************************************************************
  // Register state
  // ******************************************************************
  logic [31:0] ue_status_q;
  logic [31:0] ue_mask_q;
  logic [1:0] int_status_r;
  logic [1:0] int_status_nxt;
  logic [1:0] int_mask_r;
  logic [1:0] int_mask_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic report_r;
  logic report_nxt;
  logic [31:0] report_vec_r;
  logic [31:0] report_vec_nxt;

  // ******************************************************************
  // Address decode
  // ******************************************************************
  wire wr_status = req.wr && addr_hit(req.addr, aeu_pkg::UE_STATUS_OFS);
  wire wr_mask = req.wr && addr_hit(req.addr, aeu_pkg::UE_MASK_OFS);
  wire wr_int_mask = req.wr && addr_hit(req.addr, aeu_pkg::INT_MASK_OFS);
  wire rd_int_status = req.rd && addr_hit(req.addr, aeu_pkg::INT_STATUS_OFS);
  wire sel_status = addr_hit(req.addr, aeu_pkg::UE_STATUS_OFS);
  wire sel_mask = addr_hit(req.addr, aeu_pkg::UE_MASK_OFS);
  wire sel_int_status = addr_hit(req.addr, aeu_pkg::INT_STATUS_OFS);
  wire sel_int_mask = addr_hit(req.addr, aeu_pkg::INT_MASK_OFS);

  // ******************************************************************
  // Event qualification
  // ******************************************************************
  // Surprise down is dropped before logging when the port cannot report it
  wire [31:0] evt_raw = evt_vec(evt, surprise_down_capable);
  // A set mask bit suppresses both logging and the upstream report
  wire [31:0] evt_log = evt_raw & ~ue_mask_q & aeu_pkg::UE_EVENT_BITS;
  wire [31:0] evt_hidden = evt_raw & ue_mask_q;
  // Write one clears; writes to unimplemented positions land nowhere
  wire [31:0] status_clr = wr_status ? (req.wdata & aeu_pkg::UE_IMPL_BITS) :
                           32'h0000_0000;
  wire [31:0] mask_val = req.wdata & aeu_pkg::UE_IMPL_BITS;

  // ******************************************************************
  // Sticky banks
  // ******************************************************************
  // Only the power-on reset reaches these, so errors survive a port reset
  aeu_sticky_reg #(
    .WIDTH(32),
    .IMPL(aeu_pkg::UE_IMPL_BITS),
    .RST(aeu_pkg::UE_STATUS_RST)
  ) u_status (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_bits(evt_log),
    .clr_bits(status_clr),
    .load(1'b0),
    .load_val(32'h0000_0000),
    .q(ue_status_q)
  );

  aeu_sticky_reg #(
    .WIDTH(32),
    .IMPL(aeu_pkg::UE_IMPL_BITS),
    .RST(aeu_pkg::UE_MASK_RST)
  ) u_mask (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_bits(32'h0000_0000),
    .clr_bits(32'h0000_0000),
    .load(wr_mask),
    .load_val(mask_val),
    .q(ue_mask_q)
  );

  // ******************************************************************
  // Interrupt bank and read path
  // ******************************************************************
  wire [1:0] int_set = {|evt_hidden, |evt_log};
  // A new event in the clearing read cycle stays pending
  assign int_status_nxt = int_set | (rd_int_status ? 2'h0 : int_status_r);
  assign int_mask_nxt = wr_int_mask ? req.wdata[1:0] : int_mask_r;
  assign irq_nxt = |(int_status_nxt & int_mask_nxt);
  assign report_nxt = |evt_log;
  assign report_vec_nxt = evt_log;

  // Unmapped addresses read as zero
  wire [31:0] rd_mux = sel_status ? ue_status_q :
                       sel_mask ? ue_mask_q :
                       sel_int_status ? {30'h0000_0000, int_status_r} :
                       sel_int_mask ? {30'h0000_0000, int_mask_r} :
                       aeu_pkg::RDATA_IDLE;
  assign rdata_nxt = req.rd ? rd_mux : aeu_pkg::RDATA_IDLE;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_status_r <= aeu_pkg::INT_STATUS_RST;
      int_mask_r <= aeu_pkg::INT_MASK_RST;
      irq_r <= 1'b0;
    end else if (!port_rst_n) begin
      int_status_r <= aeu_pkg::INT_STATUS_RST;
      int_mask_r <= aeu_pkg::INT_MASK_RST;
      irq_r <= 1'b0;
    end else begin
      int_status_r <= int_status_nxt;
      int_mask_r <= int_mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Read data and report pulses are not sticky
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= aeu_pkg::RDATA_IDLE;
      report_r <= 1'b0;
      report_vec_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
      report_r <= report_nxt;
      report_vec_r <= report_vec_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign err_report = report_r;
  assign err_report_vec = report_vec_r;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_link_err_set: assert property (
    evt.link_protocol && !ue_mask_q[aeu_pkg::LINK_PROTO_BIT]
    |=> ue_status_q[aeu_pkg::LINK_PROTO_BIT]
  ) else $error("link protocol error not logged");

  a_sdown_gated: assert property (
    !surprise_down_capable && !ue_status_q[aeu_pkg::SDOWN_BIT]
    |=> !ue_status_q[aeu_pkg::SDOWN_BIT]
  ) else $error("surprise down logged without capability");

  a_sdown_set: assert property (
    evt.surprise_down && surprise_down_capable && !ue_mask_q[aeu_pkg::SDOWN_BIT]
    |-> ##1 ue_status_q[aeu_pkg::SDOWN_BIT] && err_report
  ) else $error("surprise down not logged");

  a_poison_set: assert property (
    evt.poisoned && !ue_mask_q[aeu_pkg::POISON_BIT]
    |=> ue_status_q[aeu_pkg::POISON_BIT] && err_report_vec[aeu_pkg::POISON_BIT]
  ) else $error("poisoned packet not logged");

  a_flow_set: assert property (
    evt.flow_credit && !ue_mask_q[aeu_pkg::FLOW_BIT] && !wr_status
    ##1 !wr_status
    |=> ue_status_q[aeu_pkg::FLOW_BIT] [*1]
  ) else $error("flow control error not held");

  a_cpl_report: assert property (
    evt.unexpected_cpl && !ue_mask_q[aeu_pkg::UNEXP_CPL_BIT]
    |=> err_report && err_report_vec[aeu_pkg::UNEXP_CPL_BIT]
        && ue_status_q[aeu_pkg::UNEXP_CPL_BIT]
  ) else $error("unexpected completion not reported");

  a_ovf_set: assert property (
    evt.rcv_overflow && !ue_mask_q[aeu_pkg::OVERFLOW_BIT]
    |=> ue_status_q[aeu_pkg::OVERFLOW_BIT]
  ) else $error("receiver overflow not logged");

  a_malf_cause: assert property (
    $rose(ue_status_q[aeu_pkg::MALFORMED_BIT]) |-> $past(evt.malformed)
  ) else $error("malformed bit set without cause");

  a_ecrc_set: assert property (
    evt.ecrc && !ue_mask_q[aeu_pkg::ECRC_BIT]
    |=> ue_status_q[aeu_pkg::ECRC_BIT]
  ) else $error("ecrc failure not logged");

  a_ur_set: assert property (
    evt.unsupported && !ue_mask_q[aeu_pkg::UNSUP_BIT]
    |=> ue_status_q[aeu_pkg::UNSUP_BIT] && err_report
  ) else $error("unsupported request not logged");

  a_bit14_zero: assert property (
    req.rd |=> !reg_rdata[aeu_pkg::CPL_TIMEOUT_BIT] && !ue_status_q[aeu_pkg::CPL_TIMEOUT_BIT]
        && !ue_mask_q[aeu_pkg::CPL_TIMEOUT_BIT]
  ) else $error("bit 14 not zero");

  a_bit15_zero: assert property (
    req.rd |=> !reg_rdata[aeu_pkg::CPL_ABORT_BIT]
        && !ue_status_q[aeu_pkg::CPL_ABORT_BIT] && !ue_mask_q[aeu_pkg::CPL_ABORT_BIT]
  ) else $error("bit 15 not zero");

  a_masked_nolog: assert property (
    (ue_status_q & ~$past(ue_status_q) & $past(ue_mask_q)) == 32'h0000_0000
  ) else $error("masked event logged");

  a_masked_noreport: assert property (
    (err_report_vec & $past(ue_mask_q)) == 32'h0000_0000
  ) else $error("masked event reported");

  a_mask_write: assert property (
    wr_mask |=> ue_mask_q == ($past(req.wdata) & aeu_pkg::UE_IMPL_BITS)
  ) else $error("mask write not stored");

  a_legacy_quiet: assert property (
    !$rose(ue_status_q[aeu_pkg::LEGACY_BIT])
  ) else $error("legacy status bit set by hardware");

  a_w1c_clear: assert property (
    wr_status && req.wdata[aeu_pkg::LINK_PROTO_BIT] && !evt.link_protocol
    |=> !ue_status_q[aeu_pkg::LINK_PROTO_BIT]
  ) else $error("write one did not clear");

  a_w0_keep: assert property (
    wr_status && !req.wdata[aeu_pkg::ECRC_BIT] && ue_status_q[aeu_pkg::ECRC_BIT]
    |=> ue_status_q[aeu_pkg::ECRC_BIT]
  ) else $error("write zero changed status");

  a_set_wins: assert property (
    wr_status && req.wdata[aeu_pkg::UNSUP_BIT] && evt.unsupported
        && !ue_mask_q[aeu_pkg::UNSUP_BIT]
    |=> ue_status_q[aeu_pkg::UNSUP_BIT]
  ) else $error("clear beat a new event");

  a_reserved_zero: assert property (
    req.rd && (sel_status || sel_mask)
    |=> (reg_rdata & ~aeu_pkg::UE_IMPL_BITS) == 32'h0000_0000
  ) else $error("reserved bits not zero");

  a_irq_level: assert property (
    port_rst_n |-> irq == |(int_status_r & int_mask_r)
  ) else $error("interrupt level mismatch");

  // ******************************************************************
  // Report, hold and read-back checks
  // ******************************************************************
  a_link_report: assert property (
    evt.link_protocol && !ue_mask_q[aeu_pkg::LINK_PROTO_BIT]
    |=> err_report && err_report_vec[aeu_pkg::LINK_PROTO_BIT]
  ) else $error("link protocol error not reported");

  a_flow_report: assert property (
    evt.flow_credit && !ue_mask_q[aeu_pkg::FLOW_BIT]
    |=> err_report && err_report_vec[aeu_pkg::FLOW_BIT]
  ) else $error("flow control error not reported");

  a_ovf_report: assert property (
    evt.rcv_overflow && !ue_mask_q[aeu_pkg::OVERFLOW_BIT]
    |=> err_report && err_report_vec[aeu_pkg::OVERFLOW_BIT]
  ) else $error("receiver overflow not reported");

  a_malf_set: assert property (
    evt.malformed && !ue_mask_q[aeu_pkg::MALFORMED_BIT]
    |=> ue_status_q[aeu_pkg::MALFORMED_BIT] && err_report_vec[aeu_pkg::MALFORMED_BIT]
  ) else $error("malformed packet not logged");

  a_ecrc_report: assert property (
    evt.ecrc && !ue_mask_q[aeu_pkg::ECRC_BIT]
    |=> err_report && err_report_vec[aeu_pkg::ECRC_BIT]
  ) else $error("ecrc failure not reported");

  a_ur_report: assert property (
    evt.unsupported && !ue_mask_q[aeu_pkg::UNSUP_BIT]
    |=> err_report_vec[aeu_pkg::UNSUP_BIT]
  ) else $error("unsupported request not reported");

  a_poison_cause: assert property (
    $rose(ue_status_q[aeu_pkg::POISON_BIT]) |-> $past(evt.poisoned)
  ) else $error("poisoned bit set without cause");

  a_sdown_noreport: assert property (
    !surprise_down_capable |=> !err_report_vec[aeu_pkg::SDOWN_BIT]
  ) else $error("surprise down reported without capability");

  a_no_report_idle: assert property (
    evt == '0 |=> !err_report && err_report_vec == 32'h0000_0000
  ) else $error("report without event");

  a_mask_hold: assert property (
    !wr_mask |=> $stable(ue_mask_q)
  ) else $error("mask changed without write");

  a_status_hold: assert property (
    !wr_status && evt == '0 |=> $stable(ue_status_q)
  ) else $error("status changed without cause");

  a_status_read: assert property (
    req.rd && sel_status |=> reg_rdata == $past(ue_status_q)
  ) else $error("status read mismatch");

  a_mask_read: assert property (
    req.rd && sel_mask |=> reg_rdata == $past(ue_mask_q)
  ) else $error("mask read mismatch");

  a_rdata_idle: assert property (
    !req.rd |=> reg_rdata == aeu_pkg::RDATA_IDLE
  ) else $error("read data outside read cycle");

  a_int_rd_clear: assert property (
    rd_int_status && evt == '0 && port_rst_n |=> int_status_r == aeu_pkg::INT_STATUS_RST
  ) else $error("interrupt status not cleared by read");

  a_port_rst_clear: assert property (
    !port_rst_n
    |=> !irq && int_status_r == aeu_pkg::INT_STATUS_RST && int_mask_r == aeu_pkg::INT_MASK_RST
  ) else $error("port reset did not clear interrupt bank");

  c_logged_irq: cover property (evt.link_protocol ##1 ue_status_q[4] ##1 irq);
  c_masked_evt: cover property (evt.ecrc && ue_mask_q[aeu_pkg::ECRC_BIT]);
  c_status_clr: cover property (ue_status_q[16] ##1 wr_status ##1 !ue_status_q[16]);
  c_status_read: cover property (req.rd && sel_status && ue_status_q != 32'h0000_0000);
  c_hidden_irq: cover property (int_status_r[aeu_pkg::INT_HIDDEN_BIT] && irq);
endmodule

// ---- verification/aeu_evt_model.sv ----
// Stand-in for the link and transaction error detectors.
// Assumes the bench calls fire() and that core_clk is the block clock.
`timescale 1ns/1ns
module aeu_evt_model (
  input wire logic core_clk,
  output aeu_pkg::aeu_evt_t evt
);
  // ****************
  // Pulse source
  // ****************
  initial begin
    evt = '0;
  end
  // One-cycle pulses only: a held level would log the event every cycle
  task automatic fire(input logic [8:0] bits);
    begin
      @(posedge core_clk);
      evt <= bits;
      @(posedge core_clk);
      evt <= '0;
    end
  endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the uncorrectable error status and mask bank.
// Assumes the one-cycle strobe register port and the detector model.
`timescale 1ns/1ns
module tb;
  // ****************
  // Signals
  // ****************
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic port_rst_n = 1'b1;
  logic surprise_down_capable = 1'b1;
  aeu_pkg::aeu_req_t req = '0;
  aeu_pkg::aeu_evt_t evt;
  logic [31:0] reg_rdata;
  logic irq;
  logic err_report;
  logic [31:0] err_report_vec;
  logic [31:0] rd_val;
  logic [31:0] exp_st;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  // Status position of each event input, indexed by evt bit
  int unsigned pos [9] = '{aeu_pkg::UNSUP_BIT, aeu_pkg::ECRC_BIT, aeu_pkg::MALFORMED_BIT,
    aeu_pkg::OVERFLOW_BIT, aeu_pkg::UNEXP_CPL_BIT, aeu_pkg::FLOW_BIT, aeu_pkg::POISON_BIT,
    aeu_pkg::SDOWN_BIT, aeu_pkg::LINK_PROTO_BIT};

  always #50 core_clk = ~core_clk;

  aeu_uncorr_err_top aeu_uncorr_err_top_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .port_rst_n(port_rst_n),
    .req(req),
    .evt(evt),
    .surprise_down_capable(surprise_down_capable),
    .reg_rdata(reg_rdata),
    .irq(irq),
    .err_report(err_report),
    .err_report_vec(err_report_vec)
  );

  aeu_evt_model aeu_evt_model_inst (
    .core_clk(core_clk),
    .evt(evt)
  );

  // ****************
  // Tasks
  // ****************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp) begin
        n_fail++;
        $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge core_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge core_clk);
      req.wr <= 1'b0;
    end
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
    begin
      @(posedge core_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge core_clk);
      req.rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
      chk(name, rd_val, exp);
    end
  endtask

  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask

  // ****************
  // Timeout
  // ****************
  // Tests need about 110 cycles; the ceiling of 3000 leaves ample margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ****************
  // Tests
  // ****************
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(aeu_pkg::UE_STATUS_OFS, 32'h0000_0000, "status rst");
    rd_chk(aeu_pkg::UE_MASK_OFS, 32'h0000_0000, "mask rst");
    wr(aeu_pkg::UE_MASK_OFS, 32'hFFFF_FFFF);
    rd_chk(aeu_pkg::UE_MASK_OFS, 32'h001F_3031, "mask ones");
    wr(aeu_pkg::UE_MASK_OFS, 32'h0000_0000);
    done_test("reset and mask");

    exp_st = 32'h0000_0000;
    for (int i = 0; i < 9; i++) begin
      aeu_evt_model_inst.fire(9'h001 << i);
      #1;
      chk("report", {31'h0, err_report}, 32'h0000_0001);
      chk("report vec", err_report_vec, 32'h0000_0001 << pos[i]);
      exp_st = exp_st | (32'h0000_0001 << pos[i]);
      rd_chk(aeu_pkg::UE_STATUS_OFS, exp_st, "status evt");
    end
    rd_chk(aeu_pkg::UE_STATUS_OFS, 32'h001F_3030, "all events");
    done_test("events");

    wr(aeu_pkg::UE_STATUS_OFS, 32'h0000_0010);
    wr(aeu_pkg::UE_STATUS_OFS, 32'h0000_0000);
    rd_chk(aeu_pkg::UE_STATUS_OFS, 32'h001F_3020, "w1c");
    @(posedge core_clk);
    port_rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    port_rst_n <= 1'b1;
    rd_chk(aeu_pkg::UE_STATUS_OFS, 32'h001F_3020, "sticky");
    rd_chk(aeu_pkg::INT_STATUS_OFS, 32'h0000_0000, "port rst int");
    wr(aeu_pkg::UE_STATUS_OFS, 32'hFFFF_FFFF);
    rd_chk(aeu_pkg::UE_STATUS_OFS, 32'h0000_0000, "cleared");
    done_test("clear and sticky");

    wr(aeu_pkg::INT_MASK_OFS, 32'h0000_0001);
    wr(aeu_pkg::UE_MASK_OFS, 32'hFFFF_FFFF);
    aeu_evt_model_inst.fire(9'h1FF);
    #1;
    chk("masked report", {31'h0, err_report}, 32'h0000_0000);
    @(posedge core_clk);
    #1;
    chk("masked irq", {31'h0, irq}, 32'h0000_0000);
    rd_chk(aeu_pkg::UE_STATUS_OFS, 32'h0000_0000, "masked status");
    rd_chk(aeu_pkg::INT_STATUS_OFS, 32'h0000_0002, "int masked");
    wr(aeu_pkg::UE_MASK_OFS, 32'h0000_0000);
    @(posedge core_clk);
    surprise_down_capable <= 1'b0;
    aeu_evt_model_inst.fire(9'h080);
    #1;
    chk("sdown report", {31'h0, err_report}, 32'h0000_0000);
    rd_chk(aeu_pkg::UE_STATUS_OFS, 32'h0000_0000, "sdown gated");
    @(posedge core_clk);
    surprise_down_capable <= 1'b1;
    aeu_evt_model_inst.fire(9'h002);
    #1;
    chk("irq on", {31'h0, irq}, 32'h0000_0001);
    rd_chk(aeu_pkg::INT_STATUS_OFS, 32'h0000_0001, "int logged");
    @(posedge core_clk);
    #1;
    chk("irq off", {31'h0, irq}, 32'h0000_0000);
    done_test("interrupts and masking");

    wr(12'h200, 32'hFFFF_FFFF);
    rd_chk(12'h200, 32'h0000_0000, "unmapped");
    rd_chk(aeu_pkg::UE_STATUS_OFS, 32'h0008_0000, "status kept");
    done_test("unmapped");

    wr(aeu_pkg::INT_MASK_OFS, 32'h0000_0002);
    wr(aeu_pkg::UE_MASK_OFS, 32'h0000_2000);
    aeu_evt_model_inst.fire(9'h060);
    #1;
    chk("part vec", err_report_vec, 32'h0000_1000);
    chk("hidden irq", {31'h0, irq}, 32'h0000_0001);
    rd_chk(aeu_pkg::UE_STATUS_OFS, 32'h0008_1000, "part status");
    rd_chk(aeu_pkg::INT_STATUS_OFS, 32'h0000_0003, "int both");
    done_test("partial mask");
    report_and_stop();
  end
endmodule
